// ### core/dart_pkg.sv
// Purpose: shared constants for the command decode and bank timing block
// Assumes: core_clk at 50 MHz; link_clk is the controller's memory clock
// Notes: times are held in ns, cycle counts on core_clk are derived here

package dart_pkg;
    // ------------------------------------------------------------
    // organisation
    // ------------------------------------------------------------
    localparam int RANKS = 2;
    localparam int BANKS = 8;
    localparam int NUM_BANKS_ALL = RANKS * BANKS;
    localparam int BA_W = 3;
    localparam int RB_W = 4;
    localparam int ROW_W = 15;
    localparam int COL_W = 10;
    localparam int CA_W = 10;
    localparam int DQ_W = 32;
    localparam int DQS_W = 4;
    localparam int INFO_W = 1 + BA_W + COL_W;

    // command bit positions on the rising half
    localparam int CA_BA_LSB = 7;
    localparam int CA_AB_POS = 4;
    localparam int CA_COLR_LSB = 5;
    localparam int CA_ROWR_LSB = 2;

    // ------------------------------------------------------------
    // row timing, ns and core cycles
    // ------------------------------------------------------------
    localparam int CORE_CLK_NS = 20;
    localparam int ACT_TO_ACCESS_DELAY_NS = 18;
    localparam int ROW_ACTIVE_TIME_NS = 42;
    localparam int SINGLE_BANK_PRECHARGE_TIME_NS = 18;
    localparam int ALL_BANK_PRECHARGE_TIME_NS = 21;
    localparam int ROW_CYCLE_TIME_NS = 60;
    localparam int BANK_TO_BANK_ACT_DELAY_NS = 10;
    localparam int FOUR_ACTIVATE_WINDOW_NS = 50;
    localparam int FAW_ACTS = 4;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
    localparam logic [CNT_W-1:0] RCD_CYC =
        CNT_W'((ACT_TO_ACCESS_DELAY_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
    localparam logic [CNT_W-1:0] RAS_CYC =
        CNT_W'((ROW_ACTIVE_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
    localparam logic [CNT_W-1:0] RPPB_CYC =
        CNT_W'((SINGLE_BANK_PRECHARGE_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
    localparam logic [CNT_W-1:0] RPAB_CYC =
        CNT_W'((ALL_BANK_PRECHARGE_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
    localparam logic [CNT_W-1:0] RC_CYC =
        CNT_W'((ROW_CYCLE_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
    localparam logic [CNT_W-1:0] RRD_CYC =
        CNT_W'((BANK_TO_BANK_ACT_DELAY_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
    // window rounded up to whole clocks
    localparam logic [CNT_W-1:0] FAW_CYC =
        CNT_W'((FOUR_ACTIVATE_WINDOW_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);

    // ------------------------------------------------------------
    // read path, counted in link clocks
    // ------------------------------------------------------------
    localparam int READ_LATENCY_CYCLES = 6;
    localparam int RD_DLY = READ_LATENCY_CYCLES - 2;
    localparam logic [1:0] BEAT_LAST = 2'h3;
    localparam logic [1:0] BEAT_SEAM = 2'h2;

    // ------------------------------------------------------------
    // command word crossing to core, and violation bits
    // ------------------------------------------------------------
    localparam int XF_W = 8;
    localparam int XF_CMD_LSB = 5;
    localparam int XF_RANK_POS = 4;
    localparam int XF_BANK_LSB = 1;
    localparam int XF_ALL_POS = 0;
    localparam int NUM_VIOL = 8;
    localparam int BANK_VIOL_W = 6;
    localparam int V_ACC_CLOSED = 0;
    localparam int V_RCD = 1;
    localparam int V_ACT_OPEN = 2;
    localparam int V_RAS = 3;
    localparam int V_RP = 4;
    localparam int V_RC = 5;
    localparam int V_RRD = 6;
    localparam int V_FAW = 7;

    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_ACT = 3'b001,
        CMD_RD = 3'b010,
        CMD_WR = 3'b011,
        CMD_PRE = 3'b100
    } dart_cmd_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_PREAMBLE = 2'b01,
        RD_BURST = 2'b10
    } dart_rd_e;

    // age counters stop at the top instead of wrapping
    function automatic logic [CNT_W-1:0] dart_sat_inc(input logic [CNT_W-1:0] v);
        dart_sat_inc = (v == CNT_MAX) ? v : v + 6'h01;
    endfunction
endpackage

// ### core/dart_bank_timer.sv
// Purpose: open/closed state and row timers of one bank
// Assumes: act, acc and pre are one-cycle pulses on core_clk
// Notes: err is combinational, the parent keeps it sticky
`timescale 1ns/1ps
`default_nettype none

module dart_bank_timer
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic act,
    input wire logic acc,
    input wire logic pre,
    input wire logic pre_all,
    output logic is_open,
    output logic [dart_pkg::BANK_VIOL_W-1:0] err
);
    import dart_pkg::*;

    logic open_q, open_d;
    logic [CNT_W-1:0] since_act_q, since_act_d;
    logic [CNT_W-1:0] since_pre_q, since_pre_d;
    logic [CNT_W-1:0] rp_need_q, rp_need_d;

    // next state and checks on each command
    always_comb
    begin
        open_d = open_q;
        since_act_d = dart_sat_inc(since_act_q);
        since_pre_d = dart_sat_inc(since_pre_q);
        rp_need_d = rp_need_q;
        err = '0;
        if (act)
        begin
            err[V_ACT_OPEN] = open_q;
            err[V_RP] = !open_q && (since_pre_q < rp_need_q);
            err[V_RC] = since_act_q < RC_CYC;
            open_d = 1'b1;
            since_act_d = '0;
        end
        if (acc)
        begin
            err[V_ACC_CLOSED] = !open_q;
            err[V_RCD] = open_q && (since_act_q < RCD_CYC);
        end
        if (pre)
        begin
            err[V_RAS] = open_q && (since_act_q < RAS_CYC);
            open_d = 1'b0;
            since_pre_d = '0;
            rp_need_d = pre_all ? RPAB_CYC : RPPB_CYC;
        end
    end

    // idle bank starts closed with long-expired timers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            open_q <= 1'b0;
            since_act_q <= CNT_MAX;
            since_pre_q <= CNT_MAX;
            rp_need_q <= RPPB_CYC;
        end
        else if (clk_en)
        begin
            open_q <= open_d;
            since_act_q <= since_act_d;
            since_pre_q <= since_pre_d;
            rp_need_q <= rp_need_d;
        end
    end

    assign is_open = open_q;
endmodule
`default_nettype wire

// ### core/dart_top.sv
// Purpose: memory-side command decode, bank timing watch and read burst output
// Assumes: link_clk is the controller's memory clock, much slower than core_clk
// Notes: read data is a pattern of address and beat, there is no array
`timescale 1ns/1ps
`default_nettype none

module dart_top
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic link_clk,
    input wire logic [dart_pkg::RANKS-1:0] cs_n,
    input wire logic [dart_pkg::RANKS-1:0] cke,
    input wire logic [dart_pkg::CA_W-1:0] ca,
    input wire logic [dart_pkg::NUM_VIOL-1:0] viol_clr,
    output logic [dart_pkg::DQ_W-1:0] dq_o,
    output logic dq_oe,
    output logic [dart_pkg::DQS_W-1:0] dqs_o,
    output logic dqs_oe,
    output logic [dart_pkg::NUM_BANKS_ALL-1:0] bank_open,
    output logic [dart_pkg::NUM_VIOL-1:0] viol
);
    import dart_pkg::*;

    // one read beat: address fields, column stepped by the beat
    function automatic logic [DQ_W-1:0] dart_beat(input logic [INFO_W-1:0] info,
        input logic [ROW_W-1:0] row, input logic [2:0] beat);
        dart_beat = {info[INFO_W-1 -: RB_W], row, info[COL_W-1:0] + {7'h00, beat}, beat};
    endfunction

    // ------------------------------------------------------------
    // link domain: reset and pin capture
    // ------------------------------------------------------------

    // reset carried into link_clk, the first stage feeds only the second
    logic lrst_s1_q, lrst_s2_q;
    always_ff @(posedge link_clk)
    begin
        lrst_s1_q <= rst_n;
        lrst_s2_q <= lrst_s1_q;
    end

    // select and enable on rising edge only, command bits on both
    logic [CA_W-1:0] ca_r_q, ca_f_q;
    logic [RANKS-1:0] cs_n_r_q, cke_r_q;
    always_ff @(posedge link_clk)
    begin
        if (!lrst_s2_q)
        begin
            ca_r_q <= '0;
            cs_n_r_q <= '1;
            cke_r_q <= '0;
        end
        else
        begin
            ca_r_q <= ca;
            cs_n_r_q <= cs_n;
            cke_r_q <= cke;
        end
    end

    // falling half of the same command cycle
    always_ff @(negedge link_clk)
    begin
        if (!lrst_s2_q)
            ca_f_q <= '0;
        else
            ca_f_q <= ca;
    end

    // ------------------------------------------------------------
    // link domain: command decode
    // ------------------------------------------------------------
    dart_cmd_e dec_cmd;
    logic dec_rank;
    logic [BA_W-1:0] dec_bank;
    logic [ROW_W-1:0] dec_row;
    logic [COL_W-1:0] dec_col;
    logic dec_all;

    // both selects low counts as rank 0 only
    always_comb
    begin
        dec_rank = cs_n_r_q[0];
        dec_bank = ca_r_q[CA_BA_LSB +: BA_W];
        dec_row = {ca_r_q[CA_ROWR_LSB +: 5], ca_f_q};
        dec_col = {ca_f_q[8:1], ca_r_q[CA_COLR_LSB +: 2]};
        dec_all = ca_r_q[CA_AB_POS];
        dec_cmd = CMD_NONE;
        if (!(&cs_n_r_q) && cke_r_q[dec_rank])
        begin
            if (!ca_r_q[0] && ca_r_q[1])
                dec_cmd = CMD_ACT;
            else if (ca_r_q[0] && !ca_r_q[1])
                dec_cmd = ca_r_q[2] ? CMD_RD : CMD_WR;
            else if (ca_r_q[1:0] == 2'h3 && !ca_r_q[2] && ca_r_q[3])
                dec_cmd = CMD_PRE;
        end
    end

    // ------------------------------------------------------------
    // link domain: command word, open rows, read delay line
    // ------------------------------------------------------------
    logic [XF_W-1:0] xfer_q, xfer_d;
    logic xfer_tog_q, xfer_tog_d;
    logic [ROW_W-1:0] rows_q [NUM_BANKS_ALL];
    logic [ROW_W-1:0] rows_d [NUM_BANKS_ALL];
    logic [RD_DLY-1:0] rdv_q, rdv_d;
    logic [INFO_W-1:0] rdi_q [RD_DLY];
    logic [INFO_W-1:0] rdi_d [RD_DLY];

    // word is held until the next command so core can read it after the toggle
    always_comb
    begin
        xfer_d = xfer_q;
        xfer_tog_d = xfer_tog_q;
        rows_d = rows_q;
        rdv_d = {rdv_q[RD_DLY-2:0], dec_cmd == CMD_RD};
        rdi_d[0] = {dec_rank, dec_bank, dec_col};
        for (int i = 1; i < RD_DLY; i++)
            rdi_d[i] = rdi_q[i-1];
        if (dec_cmd != CMD_NONE)
        begin
            xfer_d = {dec_cmd, dec_rank, dec_bank, dec_all};
            xfer_tog_d = !xfer_tog_q;
        end
        if (dec_cmd == CMD_ACT)
            rows_d[{dec_rank, dec_bank}] = dec_row;
    end

    always_ff @(posedge link_clk)
    begin
        if (!lrst_s2_q)
        begin
            xfer_q <= '0;
            xfer_tog_q <= 1'b0;
            rows_q <= '{default: '0};
            rdv_q <= '0;
            rdi_q <= '{default: '0};
        end
        else
        begin
            xfer_q <= xfer_d;
            xfer_tog_q <= xfer_tog_d;
            rows_q <= rows_d;
            rdv_q <= rdv_d;
            rdi_q <= rdi_d;
        end
    end

    // ------------------------------------------------------------
    // link domain: read burst engine
    // ------------------------------------------------------------
    dart_rd_e rd_st_q, rd_st_d;
    logic [1:0] beat_q, beat_d;
    logic nxt_q, nxt_d;
    logic [INFO_W-1:0] pend_q, pend_d, cur_q, cur_d;
    logic [DQ_W-1:0] dq_hi_q, dq_hi_d, dq_lo_q, dq_lo_d;
    logic trig;
    logic [ROW_W-1:0] cur_row;

    // trigger lands two clocks before the latency edge, room for the preamble
    assign trig = rdv_q[RD_DLY-1];

    // a read four clocks behind the last runs on with no preamble gap
    always_comb
    begin
        rd_st_d = rd_st_q;
        beat_d = beat_q;
        nxt_d = nxt_q;
        pend_d = trig ? rdi_q[RD_DLY-1] : pend_q;
        cur_d = cur_q;
        unique case (rd_st_q)
            RD_IDLE:
                if (trig)
                    rd_st_d = RD_PREAMBLE;
            RD_PREAMBLE:
            begin
                rd_st_d = RD_BURST;
                beat_d = '0;
                cur_d = pend_q;
            end
            RD_BURST:
            begin
                beat_d = beat_q + 2'h1;
                if (trig && beat_q == BEAT_SEAM)
                    nxt_d = 1'b1;
                if (beat_q == BEAT_LAST)
                begin
                    nxt_d = 1'b0;
                    if (nxt_q)
                        cur_d = pend_q;
                    else if (trig)
                        rd_st_d = RD_PREAMBLE;
                    else
                        rd_st_d = RD_IDLE;
                end
            end
            default:
                rd_st_d = RD_IDLE;
        endcase
        cur_row = rows_q[cur_d[INFO_W-1 -: RB_W]];
        dq_hi_d = dart_beat(cur_d, cur_row, {beat_d, 1'b0});
        dq_lo_d = dart_beat(cur_d, cur_row, {beat_d, 1'b1});
    end

    always_ff @(posedge link_clk)
    begin
        if (!lrst_s2_q)
        begin
            rd_st_q <= RD_IDLE;
            beat_q <= '0;
            nxt_q <= 1'b0;
            pend_q <= '0;
            cur_q <= '0;
            dq_hi_q <= '0;
            dq_lo_q <= '0;
        end
        else
        begin
            rd_st_q <= rd_st_d;
            beat_q <= beat_d;
            nxt_q <= nxt_d;
            pend_q <= pend_d;
            cur_q <= cur_d;
            dq_hi_q <= dq_hi_d;
            dq_lo_q <= dq_lo_d;
        end
    end

    // strobe follows the clock, so its first rise is the latency edge;
    // output delay is modelled as zero, the controller must still allow more
    assign dqs_oe = (rd_st_q != RD_IDLE);
    assign dqs_o = (rd_st_q == RD_BURST) ? {DQS_W{link_clk}} : '0;
    assign dq_oe = (rd_st_q == RD_BURST);
    assign dq_o = link_clk ? dq_hi_q : dq_lo_q;

    // ------------------------------------------------------------
    // core domain: command crossing
    // ------------------------------------------------------------
    logic tog_s1_q, tog_s2_q, tog_s3_q;
    logic cmd_ev;
    dart_cmd_e c_cmd;
    logic c_rank;
    logic [BA_W-1:0] c_bank;
    logic c_all;

    // toggle through two stages; word is stable long before the edge shows
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end
        else if (clk_en)
        begin
            tog_s1_q <= xfer_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    assign cmd_ev = clk_en && (tog_s2_q ^ tog_s3_q);
    assign c_cmd = dart_cmd_e'(xfer_q[XF_CMD_LSB +: 3]);
    assign c_rank = xfer_q[XF_RANK_POS];
    assign c_bank = xfer_q[XF_BANK_LSB +: BA_W];
    assign c_all = xfer_q[XF_ALL_POS];

    // ------------------------------------------------------------
    // core domain: per-bank watch
    // ------------------------------------------------------------
    logic [BANK_VIOL_W-1:0] bank_err [NUM_BANKS_ALL];

    for (genvar g = 0; g < NUM_BANKS_ALL; g++)
    begin : g_bank
        logic hit, rank_hit;
        assign hit = cmd_ev && ({c_rank, c_bank} == RB_W'(g));
        assign rank_hit = cmd_ev && (c_rank == 1'(g / BANKS));
        dart_bank_timer u_timer (
            .core_clk (core_clk),
            .rst_n (rst_n),
            .clk_en (clk_en),
            .act (hit && c_cmd == CMD_ACT),
            .acc (hit && (c_cmd == CMD_RD || c_cmd == CMD_WR)),
            .pre (rank_hit && c_cmd == CMD_PRE && (c_all || hit)),
            .pre_all (c_all),
            .is_open (bank_open[g]),
            .err (bank_err[g])
        );
    end

    // ------------------------------------------------------------
    // core domain: rank spacing and sticky flags
    // ------------------------------------------------------------
    logic [CNT_W-1:0] rrd_age_q [RANKS];
    logic [CNT_W-1:0] rrd_age_d [RANKS];
    logic [CNT_W-1:0] faw_age_q [RANKS][FAW_ACTS];
    logic [CNT_W-1:0] faw_age_d [RANKS][FAW_ACTS];
    logic [NUM_VIOL-1:0] viol_q, viol_d, new_err;

    // ages of the last four activates; the oldest decides the window
    always_comb
    begin
        new_err = '0;
        for (int r = 0; r < RANKS; r++)
        begin
            rrd_age_d[r] = dart_sat_inc(rrd_age_q[r]);
            for (int k = 0; k < FAW_ACTS; k++)
                faw_age_d[r][k] = dart_sat_inc(faw_age_q[r][k]);
        end
        if (cmd_ev && c_cmd == CMD_ACT)
        begin
            new_err[V_RRD] = rrd_age_q[c_rank] < RRD_CYC;
            new_err[V_FAW] = faw_age_q[c_rank][FAW_ACTS-1] < FAW_CYC;
            rrd_age_d[c_rank] = '0;
            for (int k = FAW_ACTS - 1; k > 0; k--)
                faw_age_d[c_rank][k] = dart_sat_inc(faw_age_q[c_rank][k-1]);
            faw_age_d[c_rank][0] = '0;
        end
        for (int b = 0; b < NUM_BANKS_ALL; b++)
            new_err[BANK_VIOL_W-1:0] = new_err[BANK_VIOL_W-1:0] | bank_err[b];
        // a new violation beats a clear in the same cycle
        viol_d = (viol_q & ~viol_clr) | new_err;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rrd_age_q <= '{default: CNT_MAX};
            faw_age_q <= '{default: '{default: CNT_MAX}};
            viol_q <= '0;
        end
        else if (clk_en)
        begin
            rrd_age_q <= rrd_age_d;
            faw_age_q <= faw_age_d;
            viol_q <= viol_d;
        end
    end

    assign viol = viol_q;
endmodule
`default_nettype wire

// ### verif/dart_top_sva.sv
// Purpose: port checks for dart_top
// Assumes: link edges never meet core edges
// Notes: link sampling sees the rising ca half
`timescale 1ns/1ps
`default_nettype none
module dart_top_chk
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic link_clk,
    input wire logic [dart_pkg::RANKS-1:0] cs_n,
    input wire logic [dart_pkg::RANKS-1:0] cke,
    input wire logic [dart_pkg::CA_W-1:0] ca,
    input wire logic [dart_pkg::NUM_VIOL-1:0] viol_clr,
    input wire logic dq_oe,
    input wire logic [dart_pkg::DQS_W-1:0] dqs_o,
    input wire logic dqs_oe,
    input wire logic [dart_pkg::NUM_BANKS_ALL-1:0] bank_open,
    input wire logic [dart_pkg::NUM_VIOL-1:0] viol
);
    import dart_pkg::*;
    logic rk, taken, rd_c, act_c, pre_c;
    logic [3:0] idx_d, idx_q;
    // ----
    // link decode
    // ----
    assign rk = cs_n[0];
    assign taken = rk ? (!cs_n[1] && cke[1]) : cke[0];
    assign rd_c = taken && (ca[2:0] == 3'h5);
    assign act_c = taken && (ca[1:0] == 2'h2) && clk_en;
    assign pre_c = taken && (ca[4:0] == 5'h0B) && clk_en;
    // bank of last row command, kept for the look-ahead
    always_comb idx_d = (act_c || pre_c) ? {rk, ca[9:7]} : idx_q;
    always_ff @(posedge link_clk) idx_q <= idx_d;
    sequence burst_s;
        dqs_oe ##1 dq_oe [*4];
    endsequence
    sequence pre_s;
        !dq_oe ##1 dq_oe;
    endsequence
    chk_read_lat: assert property (@(posedge link_clk) disable iff (!rst_n)
        rd_c |-> ##6 burst_s) else $error("read burst late or short");
    chk_pre_first: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(dqs_oe) |-> pre_s) else $error("no preamble cycle");
    chk_act_opens: assert property (@(posedge link_clk) disable iff (!rst_n)
        act_c |-> ##2 bank_open[idx_q]) else $error("bank not opened");
    chk_pre_closes: assert property (@(posedge link_clk) disable iff (!rst_n)
        pre_c |-> ##2 !bank_open[idx_q]) else $error("bank not closed");
    chk_oe_nest: assert property (@(posedge core_clk) disable iff (!rst_n)
        dq_oe |-> dqs_oe) else $error("data without strobe");
    chk_strobe_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !dqs_oe |-> dqs_o == '0) else $error("idle strobe not low");
    chk_preamble_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        dqs_oe && !dq_oe |-> dqs_o == '0) else $error("preamble not low");
    chk_strobe_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
        dq_oe |-> dqs_o == {DQS_W{link_clk}}) else $error("strobe not edge aligned");
    chk_viol_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en |=> ($past(viol) & ~$past(viol_clr) & ~viol) == '0) else $error("flag lost");
    chk_freeze_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !clk_en |=> $stable(bank_open) && $stable(viol)) else $error("state moved");
endmodule
bind dart_top dart_top_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .link_clk(link_clk), .cs_n(cs_n), .cke(cke), .ca(ca), .viol_clr(viol_clr),
    .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .bank_open(bank_open), .viol(viol));
`default_nettype wire

// ### verif/dart_host_model.sv
// Purpose: host controller driving the link
// Assumes: memory clock runs free
// Notes: ca halves change 1 ns after a link edge, well before the next sampling edge
`timescale 1ns/1ps
`default_nettype none
module dart_host_model
(
    output logic link_clk,
    output logic [dart_pkg::RANKS-1:0] cs_n,
    output logic [dart_pkg::RANKS-1:0] cke,
    output logic [dart_pkg::CA_W-1:0] ca
);
    import dart_pkg::*;
    // odd offset keeps link edges off core edges
    initial
    begin
        link_clk = 1'b0;
        cs_n = '1;
        cke = '1;
        ca = '0;
        #7;
        forever #80 link_clk = ~link_clk;
    end
    // one command: rising half, falling half, release
    task automatic issue(input logic rk, input logic [CA_W-1:0] rise,
        input logic [CA_W-1:0] fall);
        @(negedge link_clk);
        #1;
        cs_n = rk ? 2'h1 : 2'h2;
        ca = rise;
        @(posedge link_clk);
        #1;
        ca = fall;
        @(negedge link_clk);
        #1;
        cs_n = '1;
        ca = ~fall;
    endtask
    // a link clock outlasts every row time, so gaps suffice
    task automatic idle(input int n);
        repeat (n) @(posedge link_clk);
    endtask
    task automatic set_cke(input logic [RANKS-1:0] v);
        @(negedge link_clk);
        #1;
        cke = v;
    endtask
endmodule
`default_nettype wire

// ### verif/test_dart_top.sv
// Purpose: self-checking bench for dart_top
// Assumes: host model makes the 160 ns link clock
// Notes: reset held past four link clocks
`timescale 1ns/1ps
`default_nettype none
module test_dart_top;
    import dart_pkg::*;
    logic core_clk;
    logic rst_n;
    logic clk_en;
    logic [NUM_VIOL-1:0] viol_clr;
    logic link_clk, dq_oe, dqs_oe;
    logic [RANKS-1:0] cs_n, cke;
    logic [CA_W-1:0] ca;
    logic [DQ_W-1:0] dq_o;
    logic [DQS_W-1:0] dqs_o;
    logic [NUM_BANKS_ALL-1:0] bank_open;
    logic [NUM_VIOL-1:0] viol;
    logic [DQ_W-1:0] beats[$];
    int miscompares = 0;
    int checks = 0;
    always #10 core_clk = ~core_clk;
    dart_host_model u_host (.link_clk(link_clk), .cs_n(cs_n), .cke(cke), .ca(ca));
    dart_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .link_clk(link_clk),
        .cs_n(cs_n), .cke(cke), .ca(ca), .viol_clr(viol_clr), .dq_o(dq_o), .dq_oe(dq_oe),
        .dqs_o(dqs_o), .dqs_oe(dqs_oe), .bank_open(bank_open), .viol(viol));
    // mid-phase capture: high half even beat, low half odd
    always @(link_clk)
    begin
        #40;
        if (dq_oe === 1'b1)
            beats.push_back(dq_o);
    end
    task automatic check(input logic [DQ_W-1:0] exp, input logic [DQ_W-1:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [DQ_W-1:0] beat(input logic rk, input logic [2:0] b,
        input logic [ROW_W-1:0] row, input logic [COL_W-1:0] c, input int k);
        return {rk, b, row, c + COL_W'(k), 3'(k)};
    endfunction
    task automatic act(input logic rk, input logic [2:0] b, input logic [ROW_W-1:0] row);
        u_host.issue(rk, {b, row[14:10], 2'h2}, row[9:0]);
        u_host.idle(3);
    endtask
    task automatic acc(input logic rk, input logic [2:0] b, input logic [COL_W-1:0] c,
        input logic rd);
        u_host.issue(rk, {b, c[1:0], 2'h0, rd, 2'h1}, {1'b0, c[9:2], 1'b0});
    endtask
    task automatic pre(input logic rk, input logic [2:0] b, input logic ab);
        u_host.issue(rk, {b, 2'h0, ab, 4'hB}, '0);
        u_host.idle(3);
    endtask
    task automatic wait_beats(input int n);
        int i;
        for (i = 0; i < 40 && beats.size() < n; i++)
            @(posedge link_clk);
        u_host.idle(2);
        check(DQ_W'(n), DQ_W'(beats.size()));
        if (i == 40)
            tally_and_finish();
    endtask
    task automatic clr(input logic [NUM_VIOL-1:0] v);
        @(posedge core_clk);
        #2;
        viol_clr = v;
        @(posedge core_clk);
        #2;
        viol_clr = '0;
    endtask
    // top column read: burst wraps inside the row
    task automatic t_read;
        int k;
        act(1'b0, 3'h3, 15'h5A5C);
        check(32'h8, DQ_W'(bank_open));
        beats.delete();
        acc(1'b0, 3'h3, 10'h3FE, 1'b1);
        wait_beats(8);
        for (k = 0; k < 8; k++)
            check(beat(1'b0, 3'h3, 15'h5A5C, 10'h3FE, k), beats[k]);
    endtask
    // two reads four clocks apart, other rank
    task automatic t_seam;
        int k;
        act(1'b1, 3'h6, 15'h7FFF);
        check(32'h4008, DQ_W'(bank_open));
        beats.delete();
        acc(1'b0, 3'h3, 10'h004, 1'b1);
        u_host.idle(3);
        acc(1'b1, 3'h6, 10'h155, 1'b1);
        wait_beats(16);
        for (k = 0; k < 16; k++)
            check(k < 8 ? beat(1'b0, 3'h3, 15'h5A5C, 10'h004, k) :
                beat(1'b1, 3'h6, 15'h7FFF, 10'h155, k - 8), beats[k]);
    endtask
    // write gives no burst; closed access and double open flag
    task automatic t_viol;
        beats.delete();
        acc(1'b0, 3'h3, 10'h010, 1'b0);
        u_host.idle(12);
        check(0, DQ_W'(beats.size()));
        check(0, DQ_W'(viol));
        acc(1'b1, 3'h2, 10'h000, 1'b1);
        act(1'b0, 3'h3, 15'h0001);
        u_host.idle(12);
        check(32'h5, DQ_W'(viol));
        clr(8'h01);
        check(32'h4, DQ_W'(viol));
        clr(8'hFF);
        check(0, DQ_W'(viol));
    endtask
    task automatic t_pre;
        pre(1'b0, 3'h3, 1'b0);
        check(32'h4000, DQ_W'(bank_open));
        act(1'b1, 3'h1, 15'h0100);
        pre(1'b1, 3'h0, 1'b1);
        check(0, DQ_W'(bank_open));
    endtask
    // disabled rank, unused code, frozen core
    task automatic t_ignore;
        u_host.set_cke(2'h1);
        act(1'b1, 3'h4, 15'h0000);
        u_host.set_cke(2'h3);
        u_host.issue(1'b0, 10'h3F3, 10'h000);
        @(posedge core_clk);
        #2;
        clk_en = 1'b0;
        act(1'b0, 3'h5, 15'h0000);
        check(0, DQ_W'(bank_open));
        clk_en = 1'b1;
        u_host.idle(3);
        check(32'h20, DQ_W'(bank_open));
        check(0, DQ_W'(viol));
    endtask
    initial
    begin
        // start values of clock, reset, enable and clears set here; link pins start in the host model
        core_clk = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        viol_clr = '0;
        repeat (40) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        u_host.idle(4);
        t_read();
        t_seam();
        t_viol();
        t_pre();
        t_ignore();
        tally_and_finish();
    end
    // hang guard
    initial
    begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
